/* File: hwmdu_pkg.sv */
// Constants shared by the multiply/divide unit files
package hwmdu_pkg;
  // ***************************************
  // Register addresses on the SFR bus
  // ***************************************
  localparam logic [7:0] HWMDU_ADDR_ACC0 = 8'he9;
  localparam logic [7:0] HWMDU_ADDR_ACC1 = 8'hea;
  localparam logic [7:0] HWMDU_ADDR_ACC2 = 8'heb;
  localparam logic [7:0] HWMDU_ADDR_ACC3 = 8'hec;
  localparam logic [7:0] HWMDU_ADDR_BLO  = 8'hed;
  localparam logic [7:0] HWMDU_ADDR_BHI  = 8'hee;
  localparam logic [7:0] HWMDU_ADDR_CTRL = 8'hef;

  // ***************************************
  // Control register fields and reset values
  // ***************************************
  localparam int          HWMDU_START_BIT = 7;
  localparam int          HWMDU_MODE_BIT  = 6;
  localparam logic [31:0] HWMDU_ACC_RST   = 32'h0000_0000;
  localparam logic [15:0] HWMDU_B_RST     = 16'h0000;
  localparam logic [7:0]  HWMDU_BYTE_ZERO = 8'h00;
  localparam logic        HWMDU_MODE_RST  = 1'b0;

  // ***************************************
  // Timing: one operation takes this many system clock periods
  // ***************************************
  localparam int          HWMDU_OP_CLOCKS = 16;
  localparam int          HWMDU_CNT_W     = 4;
  localparam logic [HWMDU_CNT_W-1:0] HWMDU_LAST_STEP = HWMDU_CNT_W'(HWMDU_OP_CLOCKS - 1);
  localparam logic [HWMDU_CNT_W-1:0] HWMDU_CNT_RST   = 4'h0;

  // Operation mode
  typedef enum logic {HWMDU_MUL, HWMDU_DIV} hwmdu_mode_e;
endpackage : hwmdu_pkg

/* File: hwmdu_engine.sv */
// Iterative 16x16 multiply and 32/16 divide engine, 16 clocks per operation
`timescale 1ns/1ps
module hwmdu_engine (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  input  wire logic        start_i,
  input  wire logic        mode_i,
  input  wire logic [31:0] acc_i,
  input  wire logic [15:0] b_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [31:0]      res_acc_o,
  output logic [15:0]      res_b_o
);
  import hwmdu_pkg::*;

  logic                   busy;
  hwmdu_mode_e            mode_q;
  logic [HWMDU_CNT_W-1:0] cnt;
  logic [31:0]            work;
  logic [15:0]            rem;
  logic [15:0]            opnd;

  // One restoring divide step: returns {remainder, shifted quotient}
  function automatic logic [47:0] div_step(input logic [15:0] r, input logic [31:0] q,
                                           input logic [15:0] d);
    logic [16:0] t;
    logic [16:0] s;
    t = {r, q[31]};
    s = t - {1'b0, d};
    if (!s[16]) begin
      div_step = {s[15:0], q[30:0], 1'b1};
    end else begin
      div_step = {t[15:0], q[30:0], 1'b0};
    end
  endfunction : div_step

  // ***************************************
  // Step arithmetic
  // ***************************************
  // Multiply: add-and-shift one multiplier bit per clock
  wire logic [16:0] mul_sum   = work[0] ? ({1'b0, work[31:16]} + {1'b0, opnd})
                                        : {1'b0, work[31:16]};
  wire logic [31:0] mul_next  = {mul_sum, work[15:1]};
  // Divide: two quotient bits per clock to finish 32 bits in 16 clocks
  wire logic [47:0] div_one   = div_step(rem, work, opnd);
  wire logic [47:0] div_two   = div_step(div_one[47:32], div_one[31:0], opnd);
  wire logic [31:0] next_work = (mode_q == HWMDU_DIV) ? div_two[31:0] : mul_next;
  wire logic [15:0] next_rem  = (mode_q == HWMDU_DIV) ? div_two[47:32] : rem;

  // Results handed back at the final step
  assign done_o    = busy && (cnt == HWMDU_LAST_STEP);
  assign busy_o    = busy;
  assign res_acc_o = next_work;
  assign res_b_o   = (mode_q == HWMDU_DIV) ? next_rem : opnd;

  // Launch latches operands and mode, then steps until the count runs out
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      busy   <= 1'b0;
      mode_q <= HWMDU_MUL;
      cnt    <= HWMDU_CNT_RST;
      work   <= HWMDU_ACC_RST;
      rem    <= HWMDU_B_RST;
      opnd   <= HWMDU_B_RST;
    end else if (ce_i) begin
      if (start_i && !busy) begin
        busy   <= 1'b1;
        mode_q <= hwmdu_mode_e'(mode_i);
        cnt    <= HWMDU_CNT_RST;
        work   <= mode_i ? acc_i : {HWMDU_B_RST, acc_i[15:0]};
        rem    <= HWMDU_B_RST;
        opnd   <= b_i;
      end else if (busy) begin
        work <= next_work;
        rem  <= next_rem;
        cnt  <= cnt + 4'h1;
        busy <= !done_o;
      end
    end
  end

  // Mode stays fixed for the whole operation
  mode_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    busy ##1 busy |-> $stable(mode_q))
    else $error("mode changed during operation");
endmodule : hwmdu_engine

/* File: hwmdu_top.sv */
// SFR-bus multiply/divide unit: operand registers, control register, engine
// How it works
// - Writing one to bit 7 launches operation
// - Bit 7 reads one while busy
// - Writing zero to bit 7 does nothing
// - Mode zero: 16x16 product into accumulator
// - Operation finishes sixteen clocks after launch
// - Mode bit 6 read/write, resets zero
`timescale 1ns/1ps
module hwmdu_top (
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       ce_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_rd_i,
  output logic      [7:0] sfr_rdata_o
);
  import hwmdu_pkg::*;

  logic [31:0] extended_accumulator;
  logic [15:0] extended_operand_b;
  logic        multiply_divide_select;
  logic [7:0]  rdata;
  logic        busy;
  logic        done;
  logic [31:0] res_acc;
  logic [15:0] res_b;

  // ***************************************
  // Address decode
  // ***************************************
  // Byte write strobes
  wire logic wr_acc0 = sfr_wr_i && (sfr_addr_i == HWMDU_ADDR_ACC0);
  wire logic wr_acc1 = sfr_wr_i && (sfr_addr_i == HWMDU_ADDR_ACC1);
  wire logic wr_acc2 = sfr_wr_i && (sfr_addr_i == HWMDU_ADDR_ACC2);
  wire logic wr_acc3 = sfr_wr_i && (sfr_addr_i == HWMDU_ADDR_ACC3);
  wire logic wr_blo  = sfr_wr_i && (sfr_addr_i == HWMDU_ADDR_BLO);
  wire logic wr_bhi  = sfr_wr_i && (sfr_addr_i == HWMDU_ADDR_BHI);
  wire logic wr_ctrl = sfr_wr_i && (sfr_addr_i == HWMDU_ADDR_CTRL);
  // Operand writes are dropped while an operation runs
  wire logic opnd_wr_ok = !busy;
  // Only a one in the start bit launches
  wire logic launch = wr_ctrl && sfr_wdata_i[HWMDU_START_BIT] && !busy;
  // Mode travels with the launching write itself
  wire logic launch_mode = sfr_wdata_i[HWMDU_MODE_BIT];
  wire logic arith_start_flag = busy;

  // Control register readback; reserved bits 5:0 read zero
  wire logic [7:0] ctrl_rd = {arith_start_flag, multiply_divide_select, 6'h00};

  // Read multiplexer, unmapped addresses read zero
  wire logic [7:0] rd_mux =
    (sfr_addr_i == HWMDU_ADDR_ACC0) ? extended_accumulator[7:0]   :
    (sfr_addr_i == HWMDU_ADDR_ACC1) ? extended_accumulator[15:8]  :
    (sfr_addr_i == HWMDU_ADDR_ACC2) ? extended_accumulator[23:16] :
    (sfr_addr_i == HWMDU_ADDR_ACC3) ? extended_accumulator[31:24] :
    (sfr_addr_i == HWMDU_ADDR_BLO)  ? extended_operand_b[7:0]     :
    (sfr_addr_i == HWMDU_ADDR_BHI)  ? extended_operand_b[15:8]    :
    (sfr_addr_i == HWMDU_ADDR_CTRL) ? ctrl_rd                     : HWMDU_BYTE_ZERO;

  // ***************************************
  // Engine
  // ***************************************
  hwmdu_engine u_engine (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .ce_i       (ce_i),
    .start_i    (launch),
    .mode_i     (launch_mode),
    .acc_i      (extended_accumulator),
    .b_i        (extended_operand_b),
    .busy_o     (busy),
    .done_o     (done),
    .res_acc_o  (res_acc),
    .res_b_o    (res_b)
  );

  // ***************************************
  // Registers
  // ***************************************
  // Operand and result registers; engine result wins over any bus write
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      extended_accumulator <= HWMDU_ACC_RST;
      extended_operand_b   <= HWMDU_B_RST;
    end else if (ce_i) begin
      if (done) begin
        extended_accumulator <= res_acc;
        extended_operand_b   <= res_b;
      end else if (opnd_wr_ok) begin
        if (wr_acc0) extended_accumulator[7:0]   <= sfr_wdata_i;
        if (wr_acc1) extended_accumulator[15:8]  <= sfr_wdata_i;
        if (wr_acc2) extended_accumulator[23:16] <= sfr_wdata_i;
        if (wr_acc3) extended_accumulator[31:24] <= sfr_wdata_i;
        if (wr_blo)  extended_operand_b[7:0]     <= sfr_wdata_i;
        if (wr_bhi)  extended_operand_b[15:8]    <= sfr_wdata_i;
      end
    end
  end

  // Mode bit, writable any time
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      multiply_divide_select <= HWMDU_MODE_RST;
    end else if (ce_i && wr_ctrl) begin
      multiply_divide_select <= sfr_wdata_i[HWMDU_MODE_BIT];
    end
  end

  // Registered read data
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      rdata <= HWMDU_BYTE_ZERO;
    end else if (ce_i && sfr_rd_i) begin
      rdata <= rd_mux;
    end
  end

  assign sfr_rdata_o = rdata;

  // ***************************************
  // Checks
  // ***************************************
  // Operands captured at launch for result checks
  logic [31:0] chk_a;
  logic [15:0] chk_b;
  logic        chk_mode;
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      chk_a    <= HWMDU_ACC_RST;
      chk_b    <= HWMDU_B_RST;
      chk_mode <= HWMDU_MODE_RST;
    end else if (ce_i && launch) begin
      chk_a    <= extended_accumulator;
      chk_b    <= extended_operand_b;
      chk_mode <= launch_mode;
    end
  end

  start_launch_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    launch && ce_i |=> busy)
    else $error("start write did not launch");

  busy_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ce_i && sfr_rd_i && (sfr_addr_i == HWMDU_ADDR_CTRL) |=>
      sfr_rdata_o[HWMDU_START_BIT] == $past(busy))
    else $error("start bit readback wrong");

  zero_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ce_i && wr_ctrl && !sfr_wdata_i[HWMDU_START_BIT] && !busy |=> !busy)
    else $error("zero write launched");

  op_time_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i || !ce_i)
    launch |-> ##1 busy ##14 busy ##1 busy ##1 !busy)
    else $error("operation length not 16 clocks");

  mult_result_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ce_i && done && !chk_mode |=> extended_accumulator == (chk_a[15:0] * chk_b))
    else $error("wrong product");

  div_result_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ce_i && done && chk_mode && (chk_b != HWMDU_B_RST) |=>
      (extended_accumulator == chk_a / chk_b) && (extended_operand_b == 16'(chk_a % chk_b)))
    else $error("wrong quotient or remainder");

  mode_reset_a: assert property (@(posedge core_clk_i)
    !rst_b_i |=> !multiply_divide_select && !busy)
    else $error("mode or start not cleared by reset");

  operand_guard_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    busy && !done && ce_i |=> $stable(extended_accumulator) && $stable(extended_operand_b))
    else $error("operands changed during operation");

  // ***************************************
  // Control register and bus checks
  // ***************************************
  // Mode bit follows every control write
  mode_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ce_i && wr_ctrl |=> multiply_divide_select == $past(sfr_wdata_i[HWMDU_MODE_BIT]))
    else $error("mode bit not written");

  // Mode bit reads back in its own position
  mode_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ce_i && sfr_rd_i && (sfr_addr_i == HWMDU_ADDR_CTRL) |=>
      sfr_rdata_o[HWMDU_MODE_BIT] == $past(multiply_divide_select))
    else $error("mode bit readback wrong");

  // Reserved and unimplemented control bits read zero
  reserved_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ce_i && sfr_rd_i && (sfr_addr_i == HWMDU_ADDR_CTRL) |=>
      sfr_rdata_o[HWMDU_MODE_BIT-1:0] == '0)
    else $error("reserved control bits not zero");

  // No early finish while steps remain
  busy_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ce_i && busy && !done |=> busy)
    else $error("operation ended early");

  // Start bit drops as the results land
  done_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ce_i && done |=> !busy)
    else $error("start bit still set after finish");

  // Idle unit stays idle without a start write
  idle_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !busy && !(ce_i && launch) |=> !busy)
    else $error("unit started without a start write");

  // Multiply leaves the B operand as loaded
  mul_b_keep_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ce_i && done && !chk_mode |=> extended_operand_b == chk_b)
    else $error("multiply altered B operand");

  // Clock enable low freezes every register
  enable_freeze_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !ce_i |=> $stable(extended_accumulator) && $stable(extended_operand_b) &&
      $stable(busy) && $stable(multiply_divide_select) && $stable(sfr_rdata_o))
    else $error("state moved with clock enable low");

  // Read data holds until the next taken read
  read_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !(ce_i && sfr_rd_i) |=> $stable(sfr_rdata_o))
    else $error("read data changed without a read");
endmodule : hwmdu_top

/* File: hwmdu_cpu_model.sv */
// SFR bus master standing in for the CPU core
`timescale 1ns/1ps
module hwmdu_cpu_model (
  input  wire logic       core_clk_i,
  input  wire logic [7:0] sfr_rdata_i,
  output logic      [7:0] sfr_addr_o,
  output logic            sfr_wr_o,
  output logic      [7:0] sfr_wdata_o,
  output logic            sfr_rd_o
);
  // Idle bus from time zero
  initial begin
    sfr_addr_o  = 8'h00;
    sfr_wr_o    = 1'b0;
    sfr_wdata_o = 8'h00;
    sfr_rd_o    = 1'b0;
  end

  // One write; released data is scrambled so stale values never look valid
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    sfr_addr_o  <= a;
    sfr_wdata_o <= d;
    sfr_wr_o    <= 1'b1;
    @(posedge core_clk_i);
    sfr_wr_o    <= 1'b0;
    sfr_wdata_o <= ~d;
  endtask : wr_reg

  // Two back-to-back reads of one address, each sampled after its taking edge
  task automatic rd_pair(input logic [7:0] a, output logic [7:0] d1, output logic [7:0] d2);
    @(posedge core_clk_i);
    sfr_addr_o <= a;
    sfr_rd_o   <= 1'b1;
    @(posedge core_clk_i);
    #1 d1 = sfr_rdata_i;
    @(posedge core_clk_i);
    sfr_rd_o   <= 1'b0;
    sfr_addr_o <= ~a;
    #1 d2 = sfr_rdata_i;
  endtask : rd_pair
endmodule : hwmdu_cpu_model

/* File: hw_multiply_divide_unit_bench.sv */
// Self-checking bench for the multiply/divide unit
`timescale 1ns/1ps
module hw_multiply_divide_unit_bench;
  import hwmdu_pkg::*;
  logic       core_clk_i;
  logic       rst_b_i;
  logic       ce_i;
  logic       sfr_wr_i;
  logic       sfr_rd_i;
  logic [7:0] sfr_addr_i;
  logic [7:0] sfr_wdata_i;
  logic [7:0] sfr_rdata_o;
  int         failures;
  int         comparisons;

  // ****************************************
  // Clock, reset and instances
  // ****************************************
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  hwmdu_top DUT (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o));

  hwmdu_cpu_model cpu (.core_clk_i(core_clk_i), .sfr_rdata_i(sfr_rdata_o),
    .sfr_addr_o(sfr_addr_i), .sfr_wr_o(sfr_wr_i), .sfr_wdata_o(sfr_wdata_i),
    .sfr_rd_o(sfr_rd_i));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Operands go in only while the unit is idle
  task automatic load(input logic [31:0] a, input logic [15:0] b);
    logic [47:0] v;
    v = {b, a};
    for (int i = 0; i < 6; i++) begin
      cpu.wr_reg(HWMDU_ADDR_ACC0 + 8'(i), v[8*i +: 8]);
    end
  endtask : load

  task automatic expect_regs(input logic [31:0] a, input logic [15:0] b);
    logic [47:0] v;
    logic [7:0]  d1;
    logic [7:0]  d2;
    v = {b, a};
    for (int i = 0; i < 6; i++) begin
      cpu.rd_pair(HWMDU_ADDR_ACC0 + 8'(i), d1, d2);
      chk("result byte", v[8*i +: 8], d1);
    end
  endtask : expect_regs

  // Launch, write control again mid-run, read busy across edges 16 and 17
  task automatic launch(input logic [7:0] ctrl, input logic [7:0] mid, input logic [7:0] last);
    logic [7:0] d1;
    logic [7:0] d2;
    cpu.wr_reg(HWMDU_ADDR_CTRL, ctrl);
    cpu.wr_reg(HWMDU_ADDR_CTRL, mid);
    repeat (12) @(posedge core_clk_i);
    cpu.rd_pair(HWMDU_ADDR_CTRL, d1, d2);
    chk("control in last busy cycle", {1'b1, last[6:0]}, d1);
    chk("control after finish", last, d2);
  endtask : launch

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [7:0] d1;
    logic [7:0] d2;
    for (int a = 'he8; a <= 'hf0; a++) begin
      cpu.rd_pair(8'(a), d1, d2);
      chk("reset value", 8'h00, d1);
    end
    cpu.wr_reg(HWMDU_ADDR_CTRL, 8'h7f);
    cpu.rd_pair(HWMDU_ADDR_CTRL, d1, d2);
    chk("mode bit and reserved bits", 8'h40, d1);
  endtask : t_reset

  // Largest operands; mode flipped and start rewritten while running
  // Mode is still one here, so only the launch write can select multiply
  task automatic t_mul();
    load(32'ha5a5_ffff, 16'hffff);
    launch(8'h80, 8'hc0, 8'h40);
    expect_regs(32'hfffe_0001, 16'hffff);
  endtask : t_mul

  // Divide with mode cleared and zero written to start while running
  task automatic t_div();
    logic [31:0] n;
    logic [31:0] q;
    logic [31:0] r;
    n = 32'hfedc_ba98;
    q = n / 32'h0000_8001;
    r = n % 32'h0000_8001;
    load(n, 16'h8001);
    launch(8'hc0, 8'h00, 8'h00);
    expect_regs(q, r[15:0]);
  endtask : t_div

  // Clock enable dropped for ten cycles mid-run: the operation pauses
  task automatic t_pause();
    logic [7:0]  d1;
    logic [7:0]  d2;
    logic [31:0] p;
    p = 32'h0000_1234 * 32'h0000_5678;
    load(32'h0000_1234, 16'h5678);
    cpu.wr_reg(HWMDU_ADDR_CTRL, 8'h80);
    @(posedge core_clk_i);
    ce_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    ce_i <= 1'b1;
    repeat (13) @(posedge core_clk_i);
    cpu.rd_pair(HWMDU_ADDR_CTRL, d1, d2);
    chk("control in last paused busy cycle", 8'h80, d1);
    chk("control after paused finish", 8'h00, d2);
    expect_regs(p, 16'h5678);
  endtask : t_pause

  // Reset in the middle of a divide clears operands, mode and start bit
  task automatic t_midreset();
    logic [7:0] d1;
    logic [7:0] d2;
    load(32'h8000_0001, 16'h0003);
    cpu.wr_reg(HWMDU_ADDR_CTRL, 8'hc0);
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    cpu.rd_pair(HWMDU_ADDR_CTRL, d1, d2);
    chk("control after mid-run reset", 8'h00, d1);
    expect_regs(32'h0000_0000, 16'h0000);
  endtask : t_midreset

  // ****************************************
  // Run control
  // ****************************************
  task automatic conclude();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (4000) @(posedge core_clk_i);
    failures++;
    conclude();
  end

  initial begin
    failures    = 0;
    comparisons = 0;
    rst_b_i     = 1'b0;
    ce_i        = 1'b1;
    repeat (20) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_mul();
    t_div();
    t_pause();
    t_midreset();
    conclude();
  end
endmodule : hw_multiply_divide_unit_bench
